// ---- rtl/psc_ctrl.sv ----
// Control registers, conversion sequencing and event pin of the sensor.
// Assumes a serial front end presents byte accesses on rd/wr strobes,
// and sensing, trim and FIFO storage blocks outside answer on ports.
`timescale 1ns/1ps
module psc_ctrl
#(
  parameter int CONV_CYCLES = psc_pkg::CONV_CYCLES,
  parameter int TRIM_WORDS = psc_pkg::TRIM_WORDS
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register access from serial front end
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [6:0] next_addr,
  output logic spi_three_wire,
  // Acquisition tick from the rate timer domain (pin level)
  input wire logic rate_tick_pin,
  output logic [2:0] rate_select,
  output logic [1:0] bw_div_sel,
  output logic quiet_active,
  // Raw sample from sensing core
  input wire logic [23:0] raw_pressure,
  input wire logic [15:0] raw_temperature,
  // FIFO flags and output bytes
  input wire logic fifo_full,
  input wire logic fifo_level_hit,
  input wire logic fifo_overwrite,
  input wire logic [6:0] fifo_count,
  input wire logic [39:0] fifo_head,
  output logic [2:0] fifo_mode,
  output logic fifo_halt_full,
  output logic [6:0] watermark_level,
  // Threshold events from comparator
  input wire logic press_high_evt,
  input wire logic press_low_evt,
  // Trim copy
  output logic trim_copy,
  output logic [3:0] trim_index,
  // Event pin
  output logic event_out_pin,
  output logic event_out_oe
);
  // ==========================================
  // Registers
  logic [7:0] rf_r, rf_nxt;
  logic [7:0] sc_r, sc_nxt;
  logic [7:0] ep_r, ep_nxt;
  logic [7:0] fc_r, fc_nxt;
  logic [6:0] wm_r, wm_nxt;
  logic [15:0] ref_r, ref_nxt;
  logic zcap_r, zcap_nxt;
  logic rcap_r, rcap_nxt;
  logic [23:0] pout_r, pout_nxt;
  logic [15:0] tout_r, tout_nxt;
  logic [2:0] rd_seen_r, rd_seen_nxt;
  logic route_data_ready_r, route_data_ready_nxt;
  psc_pkg::psc_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic tick_d_r, tick_d_nxt;
  logic tick_s;
  logic tick_rise;
  logic sample_now;
  logic [23:0] meas;
  logic held;
  logic ev_raw;
  logic ev_data;
  logic sys_wr;

  psc_sync u_tick
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d(rate_tick_pin),
    .q(tick_s)
  );

  assign tick_rise = tick_s & ~tick_d_r;
  // Host set of the trigger or trim bit wins over its hardware clear
  assign sys_wr = reg_wr && (reg_addr == psc_pkg::ADDR_SYSTEM);
  assign rate_select = rf_r[psc_pkg::RF_RATE_LSB +: 3];
  assign spi_three_wire = rf_r[psc_pkg::RF_WIRE];
  // Two-bit divider code: 0 = RATE_SELECT/2, 2 = RATE_SELECT/9, 3 = RATE_SELECT/20
  assign bw_div_sel = {rf_r[psc_pkg::RF_FILT_ON], rf_r[psc_pkg::RF_FILT_ON] & rf_r[psc_pkg::RF_FILT_WIDTH]};
  // Codes 110 and 111 are 100 Hz and 200 Hz
  assign quiet_active = sc_r[psc_pkg::SC_QUIET] & ~(rate_select[2] & rate_select[1]);
  assign watermark_level = wm_r;
  assign fifo_halt_full = fc_r[psc_pkg::FC_HALT];
  assign trim_copy = (st_r == psc_pkg::PSC_TRIM);
  assign trim_index = cnt_r[3:0];
  assign held = rf_r[psc_pkg::RF_HOLD] & route_data_ready_r & (rd_seen_r != 3'b111);
  assign meas = zcap_r ? 24'h000000 : raw_pressure - {{8{ref_r[15]}}, ref_r};

  // ==========================================
  // FIFO policy decode
  always_comb
  begin
    case ({fc_r[psc_pkg::FC_TRIG], fc_r[1:0]})
      3'b001: fifo_mode = psc_pkg::PSC_FIFO;
      3'b010, 3'b011: fifo_mode = psc_pkg::PSC_STREAM;
      3'b101: fifo_mode = psc_pkg::PSC_BYP_FIFO;
      3'b110: fifo_mode = psc_pkg::PSC_BYP_STREAM;
      3'b111: fifo_mode = psc_pkg::PSC_STREAM_FIFO;
      default: fifo_mode = psc_pkg::PSC_BYPASS;
    endcase
  end

  // ==========================================
  // Address step and read data
  always_comb
  begin
    next_addr = sc_r[psc_pkg::SC_STEP] ? reg_addr + 7'h01 : reg_addr;
    case (reg_addr)
      psc_pkg::ADDR_RATE_FILTER: reg_rdata = rf_r;
      psc_pkg::ADDR_SYSTEM: reg_rdata = sc_r;
      psc_pkg::ADDR_EVENT_PIN: reg_rdata = ep_r;
      psc_pkg::ADDR_FIFO_CTRL: reg_rdata = fc_r;
      psc_pkg::ADDR_FIFO_THRESH: reg_rdata = {1'b0, wm_r};
      psc_pkg::ADDR_REF_LOW: reg_rdata = ref_r[7:0];
      psc_pkg::ADDR_REF_HIGH: reg_rdata = ref_r[15:8];
      psc_pkg::ADDR_P_XL: reg_rdata = pout_r[7:0];
      psc_pkg::ADDR_P_L: reg_rdata = pout_r[15:8];
      psc_pkg::ADDR_P_H: reg_rdata = pout_r[23:16];
      psc_pkg::ADDR_T_L: reg_rdata = tout_r[7:0];
      psc_pkg::ADDR_T_H: reg_rdata = tout_r[15:8];
      default:
      begin
        // FIFO head bytes, one per address
        if (reg_addr >= psc_pkg::ADDR_FIFO_FIRST && reg_addr <= psc_pkg::ADDR_FIFO_LAST)
          reg_rdata = fifo_head[8 * (reg_addr - psc_pkg::ADDR_FIFO_FIRST) +: 8];
        else
          reg_rdata = 8'h00;
      end
    endcase
  end

  // ==========================================
  // Register writes, sequencing and sampling
  always_comb
  begin
    rf_nxt = rf_r;
    sc_nxt = sc_r;
    ep_nxt = ep_r;
    fc_nxt = fc_r;
    wm_nxt = wm_r;
    ref_nxt = ref_r;
    zcap_nxt = zcap_r;
    rcap_nxt = rcap_r;
    pout_nxt = pout_r;
    tout_nxt = tout_r;
    rd_seen_nxt = rd_seen_r;
    route_data_ready_nxt = route_data_ready_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    tick_d_nxt = tick_s;
    sample_now = 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        psc_pkg::ADDR_RATE_FILTER: rf_nxt = {1'b0, reg_wdata[6:0]};
        psc_pkg::ADDR_SYSTEM:
        begin
          sc_nxt = {reg_wdata[7:3] & 5'h1F, reg_wdata[2:0]};
          sc_nxt[3] = 1'b0;
          // Trigger only takes in power-down
          if (rate_select != 3'b000)
            sc_nxt[psc_pkg::SC_SINGLE] = 1'b0;
        end
        psc_pkg::ADDR_EVENT_PIN: ep_nxt = {2'b00, reg_wdata[5:0]};
        psc_pkg::ADDR_FIFO_CTRL: fc_nxt = {4'h0, reg_wdata[3:0]};
        psc_pkg::ADDR_FIFO_THRESH: wm_nxt = reg_wdata[6:0];
        default: ;
      endcase
    end
    // Output reads release the hold
    if (reg_rd)
    begin
      if (reg_addr == psc_pkg::ADDR_P_XL)
        rd_seen_nxt[0] = 1'b1;
      if (reg_addr == psc_pkg::ADDR_P_L)
        rd_seen_nxt[1] = 1'b1;
      if (reg_addr == psc_pkg::ADDR_P_H)
      begin
        rd_seen_nxt[2] = 1'b1;
        route_data_ready_nxt = 1'b0;
      end
    end
    case (st_r)
      psc_pkg::PSC_IDLE:
      begin
        if (sc_r[psc_pkg::SC_TRIM])
        begin
          st_nxt = psc_pkg::PSC_TRIM;
          cnt_nxt = 16'h0000;
        end
        else if (rate_select == 3'b000 && sc_r[psc_pkg::SC_SINGLE])
        begin
          st_nxt = psc_pkg::PSC_CONVERT;
          cnt_nxt = 16'h0000;
        end
        else if (rate_select != 3'b000 && tick_rise)
          sample_now = 1'b1;
      end
      psc_pkg::PSC_CONVERT:
      begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == 16'(CONV_CYCLES - 1))
        begin
          sample_now = 1'b1;
          sc_nxt[psc_pkg::SC_SINGLE] = sc_nxt[psc_pkg::SC_SINGLE] & sys_wr;
          st_nxt = psc_pkg::PSC_IDLE;
        end
      end
      psc_pkg::PSC_TRIM:
      begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == 16'(TRIM_WORDS - 1))
        begin
          sc_nxt[psc_pkg::SC_TRIM] = sc_nxt[psc_pkg::SC_TRIM] & sys_wr;
          st_nxt = psc_pkg::PSC_IDLE;
        end
      end
      default: st_nxt = psc_pkg::PSC_IDLE;
    endcase
    if (sample_now)
    begin
      route_data_ready_nxt = 1'b1;
      if (!held)
      begin
        pout_nxt = rcap_r ? raw_pressure : meas;
        tout_nxt = raw_temperature;
        rd_seen_nxt = 3'b000;
      end
      if (zcap_r || rcap_r)
      begin
        ref_nxt = raw_pressure[23:8];
        zcap_nxt = 1'b0;
        rcap_nxt = 1'b0;
      end
    end
    // Soft restart wins over everything else
    if (sc_r[psc_pkg::SC_RESTART])
    begin
      rf_nxt = psc_pkg::RST_RATE_FILTER;
      sc_nxt = psc_pkg::RST_SYSTEM;
      ep_nxt = psc_pkg::RST_EVENT_PIN;
      fc_nxt = psc_pkg::RST_FIFO_CTRL;
      wm_nxt = psc_pkg::RST_FIFO_THRESH[6:0];
      ref_nxt = 16'h0000;
      st_nxt = psc_pkg::PSC_IDLE;
    end
  end

  // ==========================================
  // Event pin
  always_comb
  begin
    // Earlier source wins in data mode
    if (ep_r[psc_pkg::EP_READY] & route_data_ready_r)
      ev_data = 1'b1;
    else if (ep_r[psc_pkg::EP_LEVEL] & fifo_level_hit)
      ev_data = 1'b1;
    else if (ep_r[psc_pkg::EP_OVR] & fifo_overwrite)
      ev_data = 1'b1;
    else
      ev_data = ep_r[psc_pkg::EP_FULL] & fifo_full & (fifo_count == 7'h00);
    case (ep_r[psc_pkg::EP_SRC_LSB +: 2])
      2'b00: ev_raw = ev_data;
      2'b01: ev_raw = press_high_evt;
      2'b10: ev_raw = press_low_evt;
      default: ev_raw = press_high_evt | press_low_evt;
    endcase
    event_out_pin = ev_raw ^ sc_r[psc_pkg::SC_POL];
    // Open drain drives only the low level
    event_out_oe = ~sc_r[psc_pkg::SC_DRIVE] | ~event_out_pin;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rf_r <= psc_pkg::RST_RATE_FILTER;
      sc_r <= psc_pkg::RST_SYSTEM;
      ep_r <= psc_pkg::RST_EVENT_PIN;
      fc_r <= psc_pkg::RST_FIFO_CTRL;
      wm_r <= psc_pkg::RST_FIFO_THRESH[6:0];
      ref_r <= 16'h0000;
      zcap_r <= 1'b0;
      rcap_r <= 1'b0;
      pout_r <= 24'h000000;
      tout_r <= 16'h0000;
      rd_seen_r <= 3'b111;
      route_data_ready_r <= 1'b0;
      st_r <= psc_pkg::PSC_TRIM; // power-up trim copy
      cnt_r <= 16'h0000;
      tick_d_r <= 1'b0;
    end
    else
    begin
      rf_r <= rf_nxt;
      sc_r <= sc_nxt;
      ep_r <= ep_nxt;
      fc_r <= fc_nxt;
      wm_r <= wm_nxt;
      ref_r <= ref_nxt;
      zcap_r <= zcap_nxt;
      rcap_r <= rcap_nxt;
      pout_r <= pout_nxt;
      tout_r <= tout_nxt;
      rd_seen_r <= rd_seen_nxt;
      route_data_ready_r <= route_data_ready_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tick_d_r <= tick_d_nxt;
    end
  end
endmodule

// ---- rtl/psc_pkg.sv ----
// Constants and types shared by the pressure sensor control logic.
// Assumes a single 200 MHz core clock and an external serial front end.
// How it works
// - rate code 000 stops periodic output updates
// - codes 001..111 select 1 to 200 Hz
// - nonzero rate runs continuous paired sampling
// - trigger in power-down runs one conversion
// - bandwidth RATE_SELECT/2, RATE_SELECT/9 or RATE_SELECT/20
// - hold outputs until the high pressure byte at 2Ah is read
// - wire select picks 4-wire or 3-wire SPI
// - trim reload copies trims, then self-clears
// - soft restart restores defaults, then self-clears
// - event pin polarity and drive selectable
// - auto-step increments address per byte
// - quiet mode only below 100 Hz
// - source select picks data or pressure events
// - enables route ready, full, level, overwrite
// - policy field and triggered bit pick mode
// - halt-at-watermark makes watermark count full
// - watermark is seven bits, resets zero
// - FIFO output bytes at 78h to 7Ch
// - reference pressure read-only at 15h, 16h
// - zero capture is never armed by any register, so reference stays zero
package psc_pkg;
  // ==========================================
  // Register offsets
  localparam logic [6:0] ADDR_RATE_FILTER = 7'h10;
  localparam logic [6:0] ADDR_SYSTEM = 7'h11;
  localparam logic [6:0] ADDR_EVENT_PIN = 7'h12;
  localparam logic [6:0] ADDR_FIFO_CTRL = 7'h13;
  localparam logic [6:0] ADDR_FIFO_THRESH = 7'h14;
  localparam logic [6:0] ADDR_REF_LOW = 7'h15;
  localparam logic [6:0] ADDR_REF_HIGH = 7'h16;
  localparam logic [6:0] ADDR_P_XL = 7'h28;
  localparam logic [6:0] ADDR_P_L = 7'h29;
  localparam logic [6:0] ADDR_P_H = 7'h2A;
  localparam logic [6:0] ADDR_T_L = 7'h2B;
  localparam logic [6:0] ADDR_T_H = 7'h2C;
  localparam logic [6:0] ADDR_FIFO_FIRST = 7'h78;
  localparam logic [6:0] ADDR_FIFO_LAST = 7'h7C;
  // ==========================================
  // Reset values
  localparam logic [7:0] RST_RATE_FILTER = 8'h00;
  localparam logic [7:0] RST_SYSTEM = 8'h10;
  localparam logic [7:0] RST_EVENT_PIN = 8'h00;
  localparam logic [7:0] RST_FIFO_CTRL = 8'h00;
  localparam logic [7:0] RST_FIFO_THRESH = 8'h00;
  // ==========================================
  // Field positions
  localparam int RF_RATE_LSB = 4;
  localparam int RF_FILT_ON = 3;
  localparam int RF_FILT_WIDTH = 2;
  localparam int RF_HOLD = 1;
  localparam int RF_WIRE = 0;
  localparam int SC_TRIM = 7;
  localparam int SC_POL = 6;
  localparam int SC_DRIVE = 5;
  localparam int SC_STEP = 4;
  localparam int SC_RESTART = 2;
  localparam int SC_QUIET = 1;
  localparam int SC_SINGLE = 0;
  localparam int EP_FULL = 5;
  localparam int EP_LEVEL = 4;
  localparam int EP_OVR = 3;
  localparam int EP_READY = 2;
  localparam int EP_SRC_LSB = 0;
  localparam int FC_HALT = 3;
  localparam int FC_TRIG = 2;
  localparam int FC_POL_LSB = 0;
  // ==========================================
  // Timing
  localparam int CLK_HZ = 200_000_000;
  localparam int CONV_TIME_US = 5;
  localparam int CONV_CYCLES = CONV_TIME_US * (CLK_HZ / 1_000_000);
  localparam int TRIM_WORDS = 16;
  localparam int FIFO_DEPTH = 128;
  // ==========================================
  // Types
  typedef enum logic [2:0] {
    PSC_BYPASS = 3'b000,
    PSC_FIFO = 3'b001,
    PSC_STREAM = 3'b010,
    PSC_BYP_FIFO = 3'b011,
    PSC_BYP_STREAM = 3'b100,
    PSC_STREAM_FIFO = 3'b101
  } psc_fifo_mode_t;
  typedef enum logic [1:0] {
    PSC_IDLE = 2'b00,
    PSC_CONVERT = 2'b01,
    PSC_TRIM = 2'b10
  } psc_state_t;
endpackage

// ---- rtl/psc_sync.sv ----
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the input is a slow level or a clock far below ref_clk.
`timescale 1ns/1ps
module psc_sync
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Level
  input wire logic d,
  output logic q
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb
  begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end
endmodule

// ---- bench/psc_ctrl_asserts.sv ----
// Checker of register-driven outputs of the sensor control block.
// Assumes it is bound to psc_ctrl and sees only its ports.
`timescale 1ns/1ps
module psc_ctrl_asserts
#(
  parameter int CONV_CYCLES = 4,
  parameter int TRIM_WORDS = 2
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register access
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [6:0] next_addr,
  input wire logic spi_three_wire,
  // Register levels
  input wire logic [2:0] rate_select,
  input wire logic [1:0] bw_div_sel,
  input wire logic quiet_active,
  input wire logic [2:0] fifo_mode,
  input wire logic fifo_halt_full,
  input wire logic [6:0] watermark_level,
  input wire logic trim_copy,
  input wire logic event_out_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic w10, w11, w13, w14;
  logic [2:0] mode_exp;
  logic [7:0] trim_cnt_r, trim_cnt_nxt;
  assign w10 = reg_wr && reg_addr == psc_pkg::ADDR_RATE_FILTER;
  assign w11 = reg_wr && reg_addr == psc_pkg::ADDR_SYSTEM && !reg_wdata[2];
  assign w13 = reg_wr && reg_addr == psc_pkg::ADDR_FIFO_CTRL;
  assign w14 = reg_wr && reg_addr == psc_pkg::ADDR_FIFO_THRESH;
  always_comb
  begin
    if (reg_wdata[1:0] == 2'h0)
      mode_exp = psc_pkg::PSC_BYPASS;
    else if (!reg_wdata[2])
      mode_exp = reg_wdata[1] ? psc_pkg::PSC_STREAM : psc_pkg::PSC_FIFO;
    else if (reg_wdata[1:0] == 2'h1)
      mode_exp = psc_pkg::PSC_BYP_FIFO;
    else
      mode_exp = reg_wdata[0] ? psc_pkg::PSC_STREAM_FIFO : psc_pkg::PSC_BYP_STREAM;
    trim_cnt_nxt = trim_copy ? trim_cnt_r + 8'h01 : 8'h00;
  end
  // Saturation not needed: copy is short, a stuck copy trips long before wrap
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      trim_cnt_r <= 8'h00;
    else
      trim_cnt_r <= trim_cnt_nxt;
  end
  rate_follow_a: assert property (w10 |=> rate_select == $past(reg_wdata[6:4]))
    else $error("rate select not taken");
  wire_sel_a: assert property (w10 |=> spi_three_wire == $past(reg_wdata[0]))
    else $error("wire select wrong");
  bw_map_a: assert property (w10 |=> bw_div_sel == ($past(reg_wdata[3]) ?
    {1'b1, $past(reg_wdata[2])} : 2'h0)) else $error("bandwidth wrong");
  quiet_fast_a: assert property (rate_select[2:1] == 2'h3 |-> !quiet_active)
    else $error("quiet at high rate");
  step_addr_a: assert property (w11 |=> next_addr ==
    ($past(reg_wdata[4]) ? reg_addr + 7'h01 : reg_addr)) else $error("step wrong");
  push_pull_a: assert property (w11 && !reg_wdata[5] |=> event_out_oe)
    else $error("push-pull not driven");
  mode_sel_a: assert property (w13 |=> fifo_mode == $past(mode_exp))
    else $error("fifo mode wrong");
  halt_sel_a: assert property (w13 |=> fifo_halt_full == $past(reg_wdata[3]))
    else $error("halt flag wrong");
  wm_level_a: assert property (w14 |=> watermark_level == $past(reg_wdata[6:0]))
    else $error("watermark wrong");
  trim_end_a: assert property (trim_cnt_r <= TRIM_WORDS + 2)
    else $error("trim copy too long");
  cover property (w11 && reg_wdata[0]);
  cover property ($fell(trim_copy));
  cover property (w13 && reg_wdata[2]);
endmodule
bind psc_ctrl psc_ctrl_asserts #(.CONV_CYCLES(CONV_CYCLES), .TRIM_WORDS(TRIM_WORDS)) i_chk
  (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .next_addr, .spi_three_wire,
   .rate_select, .bw_div_sel, .quiet_active, .fifo_mode, .fifo_halt_full,
   .watermark_level, .trim_copy, .event_out_oe);

// ---- bench/psc_host.sv ----
// Host model making byte register accesses into the control block.
// Assumes reg_rdata answers in the cycle of the strobe.
`timescale 1ns/1ps
module psc_host
(
  // Clock
  input wire logic ref_clk,
  // Register access
  input wire logic [7:0] reg_rdata,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial
  begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Data is inverted once released, so stale bytes never look valid
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge ref_clk);
    q = reg_rdata;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
  endtask
endmodule

// ---- bench/psc_ctrl_bench.sv ----
// Self-checking bench of the sensor control block.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/1ps
module psc_ctrl_bench;
  logic ref_clk, nrst, rate_tick_pin;
  logic [6:0] reg_addr, next_addr, watermark_level, fifo_count;
  logic [7:0] reg_wdata, reg_rdata, q, d;
  logic reg_wr, reg_rd, spi_three_wire, quiet_active, fifo_halt_full, trim_copy;
  logic [2:0] rate_select, fifo_mode;
  logic [1:0] bw_div_sel;
  logic [23:0] raw_pressure, pa, pd;
  logic [15:0] raw_temperature;
  logic fifo_full, fifo_level_hit, fifo_overwrite, press_high_evt, press_low_evt;
  logic [39:0] fifo_head;
  logic [3:0] trim_index;
  logic event_out_pin, event_out_oe, pol, od;
  logic [4:0] sv;
  logic [7:0] rv [7];
  int err_total, cmp_count, n;
  psc_host i_host (.ref_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  psc_ctrl #(.CONV_CYCLES(4), .TRIM_WORDS(2)) i_dut (.ref_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .next_addr, .spi_three_wire,
    .rate_tick_pin, .rate_select, .bw_div_sel, .quiet_active, .raw_pressure,
    .raw_temperature, .fifo_full, .fifo_level_hit, .fifo_overwrite, .fifo_count,
    .fifo_head, .fifo_mode, .fifo_halt_full, .watermark_level, .press_high_evt,
    .press_low_evt, .trim_copy, .trim_index, .event_out_pin, .event_out_oe);
  // ==========================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    i_host.access(1'b1, a, v, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    i_host.access(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask
  // Tick pin pulses once, 32 ns high then 32 ns low, then 8 more clocks pass
  task automatic tick(input logic [23:0] p);
    raw_pressure = p;
    raw_temperature = 16'($urandom);
    rate_tick_pin = 1'b1;
    #32;
    rate_tick_pin = 1'b0;
    #32;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic wait_trim;
    n = 0;
    while (trim_copy !== 1'b0 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 40)
    begin
      err_total++;
      end_of_test();
    end
  endtask
  function automatic logic exp_evt(input logic [7:0] c, input logic [4:0] s);
    case (c[1:0])
      2'h0: return (c[5] & s[4]) | (c[4] & s[3]) | (c[3] & s[2]);
      2'h1: return s[1];
      2'h2: return s[0];
      default: return s[1] | s[0];
    endcase
  endfunction
  // ==========================================
  // Clock and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #300000;
    err_total++;
    end_of_test();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    {nrst, rate_tick_pin, raw_pressure, raw_temperature, fifo_count} = '0;
    {fifo_full, fifo_level_hit, fifo_overwrite, press_high_evt, press_low_evt} = '0;
    fifo_head = '0;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(8));
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    check({7'h00, event_out_oe}, 8'h01);
    wait_trim();
    rv = '{psc_pkg::RST_RATE_FILTER, psc_pkg::RST_SYSTEM, psc_pkg::RST_EVENT_PIN,
           psc_pkg::RST_FIFO_CTRL, psc_pkg::RST_FIFO_THRESH, 8'h00, 8'h00};
    for (int j = 0; j < 7; j++)
      rd(7'h10 + 7'(j), rv[j]);
    wr(psc_pkg::ADDR_REF_LOW, 8'($urandom));
    wr(7'h17, 8'hFF);
    rd(psc_pkg::ADDR_REF_LOW, 8'h00);
    rd(psc_pkg::ADDR_FIFO_THRESH, 8'h00);
    wr(psc_pkg::ADDR_SYSTEM, 8'h02);
    check({1'b0, next_addr}, 8'h11);
    wr(psc_pkg::ADDR_SYSTEM, 8'h12);
    for (int i = 0; i < 64; i++)
    begin
      d = {1'b0, 3'(i >> 3), 2'(i >> 1), 1'b0, 1'(i)};
      wr(psc_pkg::ADDR_RATE_FILTER, d);
      check({5'h00, rate_select}, {5'h00, d[6:4]});
      check({6'h00, bw_div_sel}, d[3] ? {6'h00, 1'b1, d[2]} : 8'h00);
      check({7'h00, spi_three_wire}, {7'h00, d[0]});
      if (d[6:4] != 3'h0)
        check({7'h00, quiet_active}, {7'h00, d[6:4] < 3'h6});
    end
    // Back to power-down before the quiet bit is touched again
    wr(psc_pkg::ADDR_RATE_FILTER, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      d = (k == 0) ? 8'hFF : 8'($urandom);
      wr(psc_pkg::ADDR_FIFO_CTRL, d);
      wr(psc_pkg::ADDR_FIFO_THRESH, d);
      check({1'b0, watermark_level}, {1'b0, d[6:0]});
    end
    fifo_head = 40'({$urandom, $urandom});
    for (int j = 0; j < 5; j++)
      rd(psc_pkg::ADDR_FIFO_FIRST + 7'(j), fifo_head[8 * j +: 8]);
    for (int k = 0; k < 24; k++)
    begin
      d = (k == 0) ? 8'h00 : 8'($urandom) & 8'h3B;
      sv = (k == 0) ? 5'h1F : 5'($urandom);
      pol = 1'($urandom);
      od = 1'($urandom);
      wr(psc_pkg::ADDR_SYSTEM, {1'b0, pol, od, 5'h10});
      wr(psc_pkg::ADDR_EVENT_PIN, d);
      {fifo_full, fifo_level_hit, fifo_overwrite, press_high_evt, press_low_evt} = sv;
      #1;
      check({7'h00, event_out_pin}, {7'h00, exp_evt(d, sv) ^ pol});
      check({7'h00, event_out_oe}, {7'h00, ~od | ~(exp_evt(d, sv) ^ pol)});
    end
    pa = 24'($urandom);
    wr(psc_pkg::ADDR_RATE_FILTER, 8'h10);
    tick(pa);
    wr(psc_pkg::ADDR_RATE_FILTER, 8'h12);
    tick(~pa);
    wr(psc_pkg::ADDR_EVENT_PIN, 8'h04);
    check({7'h00, event_out_pin}, {7'h00, ~pol});
    rd(psc_pkg::ADDR_P_XL, pa[7:0]);
    rd(psc_pkg::ADDR_P_L, pa[15:8]);
    rd(psc_pkg::ADDR_P_H, pa[23:16]);
    check({7'h00, event_out_pin}, {7'h00, pol});
    tick(~pa);
    rd(psc_pkg::ADDR_P_H, ~pa[23:16]);
    wr(psc_pkg::ADDR_SYSTEM, 8'h11);
    rd(psc_pkg::ADDR_SYSTEM, 8'h10);
    wr(psc_pkg::ADDR_RATE_FILTER, 8'h00);
    pd = 24'($urandom);
    raw_pressure = pd;
    wr(psc_pkg::ADDR_SYSTEM, 8'h11);
    n = 0;
    q = 8'h01;
    while (q[0] !== 1'b0 && n < 20)
    begin
      i_host.access(1'b0, psc_pkg::ADDR_SYSTEM, 8'h00, q);
      n++;
    end
    check(q, 8'h10);
    rd(psc_pkg::ADDR_P_H, pd[23:16]);
    tick(~pd);
    rd(psc_pkg::ADDR_P_H, pd[23:16]);
    wr(psc_pkg::ADDR_FIFO_THRESH, 8'h05);
    wr(psc_pkg::ADDR_SYSTEM, 8'h14);
    rd(psc_pkg::ADDR_SYSTEM, 8'h10);
    rd(psc_pkg::ADDR_FIFO_THRESH, 8'h00);
    wr(psc_pkg::ADDR_SYSTEM, 8'h90);
    // Copy starts one edge after the bit lands
    @(negedge ref_clk);
    check({7'h00, trim_copy}, 8'h01);
    wait_trim();
    rd(psc_pkg::ADDR_SYSTEM, 8'h10);
    end_of_test();
  end
endmodule
